/* bench/pwf_flash_model.sv */
// Behavioural flash device seen from the host controller's pins.
// Assumes strobes are active low and settle well before they change.
`timescale 1ns/1ns
`default_nettype none
module pwf_flash_model (
   input wire logic chip_sel_n,
   input wire logic out_gate_n,
   input wire logic wr_strobe_n,
   input wire logic [15:0] addr_pin,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe_n,
   output logic [15:0] dq_in
);
   // Log of word writes, {address, data}
   logic [31:0] lg [$];
   // Address held from the last falling strobe before a write starts
   logic [15:0] la;
   // Read word is a fixed scramble of the address
   logic [15:0] rv;
   assign rv = addr_pin ^ 16'hC3A5;
   // Drive only when selected and gated; else inverse, not a stale copy
   assign dq_in = (!chip_sel_n && !out_gate_n) ? rv : ~rv;
   // Write under way, and when both strobes came to stand low
   logic wr_on = 1'b0;
   time t_on = 0;
   // Address latch on a falling strobe; a write needs the gate high
   always @(negedge wr_strobe_n or negedge chip_sel_n) begin
      if (!wr_on) la = addr_pin;
      if (!wr_on && !wr_strobe_n && !chip_sel_n && out_gate_n) begin
         wr_on = 1'b1;
         t_on = $time;
      end
   end
   // Write ends on whichever strobe rises first; both may rise together
   always @(posedge wr_strobe_n or posedge chip_sel_n) begin
      if (wr_on && $time - t_on >= pwf_pkg::GLITCH_NS) begin
         lg.push_back({la, dq_out});
      end
      wr_on = 1'b0;
   end
endmodule
`default_nettype wire

/* bench/test_page_write_flash_interface.sv */
// Testbench: AXI4-Lite master driving the host controller and a model.
// Assumes shortened power-on, window and pause counts.
`timescale 1ns/1ns
`default_nettype none
module test_page_write_flash_interface;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [4:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0] bresp, rresp, br;
   logic cs_n, og_n, ws_n, oe_n, hv;
   logic [15:0] ap, dqo, dqi;
   int n_errors = 0, n_tests = 0;
   // Command sequences per op, {address, data}
   logic [31:0] sq [6][6] = '{
      '{32'h5555AAAA, 32'h2AAA5555, 32'h5555A0A0, 0, 0, 0},
      '{32'h5555AAAA, 32'h2AAA5555, 32'h55558080, 32'h5555AAAA,
         32'h2AAA5555, 32'h55552020},
      '{32'h5555AAAA, 32'h2AAA5555, 32'h55558080, 32'h5555AAAA,
         32'h2AAA5555, 32'h55551010},
      '{32'h555500AA, 32'h2AAA0055, 32'h55550090, 0, 0, 0},
      '{32'h555500AA, 32'h2AAA0055, 32'h55550080, 32'h555500AA,
         32'h2AAA0055, 32'h55550060},
      '{32'h555500AA, 32'h2AAA0055, 32'h555500F0, 0, 0, 0}};
   int sn [6] = '{3, 6, 6, 3, 6, 3};
   logic [3:0] so [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   // 50 MHz clock
   always #10 aclk = ~aclk;
   pwf_host #(.LOAD_WIN(200), .PWRON(50), .ID_PAUSE(10)) pwf_host_inst (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_sel_n(cs_n),
      .out_gate_n(og_n), .wr_strobe_n(ws_n), .addr_pin(ap),
      .dq_out(dqo), .dq_oe_n(oe_n), .dq_in(dqi),
      .id_high_voltage_pin(hv));
   pwf_flash_model pwf_flash_model_inst (.chip_sel_n(cs_n),
      .out_gate_n(og_n), .wr_strobe_n(ws_n), .addr_pin(ap),
      .dq_out(dqo), .dq_oe_n(oe_n), .dq_in(dqi));
   // Compare and count
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One write, address and data offered together
   task axw(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      br = bresp;
      bready <= 0;
   endtask
   // One read; data and response land in rd and rresp
   task axr(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rd = rdata;
      rready <= 0;
   endtask
   // Poll until busy drops
   task wt();
      repeat (3) @(posedge aclk);
      do axr(pwf_pkg::R_STAT); while (rd[pwf_pkg::ST_BUSY] !== 1'b0);
   endtask
   // Load one word of a page
   task ld(input logic [15:0] a, input logic [15:0] d);
      axw(pwf_pkg::R_ADDR, {16'h0000, a});
      axw(pwf_pkg::R_WDATA, {16'h0000, d});
      axw(pwf_pkg::R_CTRL, 32'h00000002);
      wt();
   endtask
   // Refused write before power-on, unmapped read, then wait for power
   task t_power();
      axr(pwf_pkg::R_STAT);
      chk(rd, 32'h00000000);
      ld(16'h0105, 16'h1234);
      chk(rd & 32'h8, 32'h8);
      chk(pwf_flash_model_inst.lg.size(), 0);
      axr(5'h14);
      chk({30'h0, rresp}, {30'h0, pwf_pkg::RESP_SLVERR});
      chk(rd, 32'h00000000);
      axw(5'h14, 32'h00000000);
      chk({30'h0, br}, {30'h0, pwf_pkg::RESP_SLVERR});
      do axr(pwf_pkg::R_STAT); while (rd[pwf_pkg::ST_READY] !== 1'b1);
   endtask
   // Read cycle returns the device word
   task t_read();
      axw(pwf_pkg::R_ADDR, 32'h00001234);
      axw(pwf_pkg::R_CTRL, 32'h00000011);
      chk({30'h0, br}, {30'h0, pwf_pkg::RESP_OK});
      wt();
      chk(rd, 32'h00000006);
      chk({31'h0, hv}, 32'h00000001);
      axr(pwf_pkg::R_RDATA);
      chk(rd, 32'h0000D191);
      axw(pwf_pkg::R_CTRL, 32'h00000000);
      repeat (2) @(posedge aclk);
      chk({31'h0, hv}, 32'h00000000);
   endtask
   // Prefixed first word, bare second word, new prefix after lapse
   task t_page();
      pwf_flash_model_inst.lg.delete();
      ld(16'h0105, 16'hBEEF);
      ld(16'h0103, 16'h0042);
      // A command op into an open page is refused
      axw(pwf_pkg::R_CTRL, 32'h00000003);
      wt();
      chk(rd & 32'h8, 32'h8);
      repeat (260) @(posedge aclk);
      ld(16'h0203, 16'h7777);
      chk(pwf_flash_model_inst.lg.size(), 9);
      chk(pwf_flash_model_inst.lg[2], 32'h5555A0A0);
      chk(pwf_flash_model_inst.lg[3], 32'h0105BEEF);
      chk(pwf_flash_model_inst.lg[4], 32'h01030042);
      chk(pwf_flash_model_inst.lg[8], 32'h02037777);
   endtask
   // Every command op emits its exact sequence
   task t_cmds();
      // Let the open page lapse first
      repeat (260) @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         pwf_flash_model_inst.lg.delete();
         axw(pwf_pkg::R_CTRL, {28'h0, so[i]});
         wt();
         chk(pwf_flash_model_inst.lg.size(), sn[i]);
         for (int j = 0; j < sn[i]; j++)
            chk(pwf_flash_model_inst.lg[j], sq[i][j]);
      end
   endtask
   // Verdict
   task end_sim();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_power();
      t_read();
      t_page();
      t_cmds();
      end_sim();
   end
   // Watchdog
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire

/* inc/pwf_cyc_if.sv */
// Carrier between the sequencer and the bus cycle engine.
// Assumes both sides run on aclk.
`timescale 1ns/1ns
`default_nettype none
interface pwf_cyc_if;
   logic req; // One-cycle start of a pin cycle
   logic wr; // High for write, low for read
   logic [15:0] addr; // Word address
   logic [15:0] wdata; // Write data
   logic [15:0] rdata; // Captured read data
   logic done; // One-cycle end of cycle
   modport seq (output req, output wr, output addr, output wdata,
      input rdata, input done);
   modport eng (input req, input wr, input addr, input wdata,
      output rdata, output done);
endinterface
`default_nettype wire

/* inc/pwf_pkg.sv */
// Package for the page-write flash host controller.
// Assumes a 50 MHz aclk; all timing counts derive from it here.
package pwf_pkg;
   // Clock period in ns
   localparam int CLK_NS = 20;
   // Load window, microseconds, and its least-time cycle count
   localparam int LOAD_WINDOW_US = 200;
   localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_US * 1000) / CLK_NS;
   // Pause after every command op, identification and others, microseconds
   localparam int ID_PAUSE_US = 10;
   localparam int ID_PAUSE_CYC = (ID_PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   // Power-on delay, milliseconds
   localparam int PWRON_MS = 5;
   localparam int PWRON_CYC = (PWRON_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   // Least strobe width, ns, rounded up to cycles (kept above glitch limit)
   localparam int GLITCH_NS = 15;
   localparam int STROBE_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
   // Page geometry
   localparam int PAGE_WORDS = 128;
   localparam int WORD_BITS = 7;
   // Erased word value
   localparam logic [15:0] ERASED = 16'hFFFF;
   // Command addresses
   localparam logic [15:0] CA_5555 = 16'h5555;
   localparam logic [15:0] CA_2AAA = 16'h2AAA;
   // Command data words
   localparam logic [15:0] CD_AA = 16'hAAAA;
   localparam logic [15:0] CD_55 = 16'h5555;
   localparam logic [15:0] CD_A0 = 16'hA0A0;
   localparam logic [15:0] CD_80 = 16'h8080;
   localparam logic [15:0] CD_20 = 16'h2020;
   localparam logic [15:0] CD_10 = 16'h1010;
   localparam logic [15:0] CD_90 = 16'h0090;
   localparam logic [15:0] CD_60 = 16'h0060;
   localparam logic [15:0] CD_F0 = 16'h00F0;
   localparam logic [15:0] CD_ID_AA = 16'h00AA;
   localparam logic [15:0] CD_ID_55 = 16'h0055;
   localparam logic [15:0] CD_ID_80 = 16'h0080;
   // Identification word addresses
   localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
   localparam logic [15:0] ID_PART_ADDR = 16'h0001;
   // Status bit positions
   localparam int POLL_LO = 7;
   localparam int POLL_HI = 15;
   localparam int TOG_LO = 6;
   localparam int TOG_HI = 14;
   // Register byte offsets
   localparam logic [4:0] R_CTRL = 5'h00;
   localparam logic [4:0] R_ADDR = 5'h04;
   localparam logic [4:0] R_WDATA = 5'h08;
   localparam logic [4:0] R_STAT = 5'h0C;
   localparam logic [4:0] R_RDATA = 5'h10;
   // Command codes written to CTRL[3:0]
   typedef enum logic [3:0] {
      PWF_OP_NONE = 4'h0,
      PWF_OP_READ = 4'h1,
      PWF_OP_LOAD = 4'h2,
      PWF_OP_PROT_ON = 4'h3,
      PWF_OP_PROT_OFF = 4'h4,
      PWF_OP_ERASE = 4'h5,
      PWF_OP_ID3 = 4'h6,
      PWF_OP_ID6 = 4'h7,
      PWF_OP_ID_EXIT = 4'h8
   } pwf_op_t;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_READY = 2;
   localparam int ST_ERR = 3;
   // AXI response codes
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/pwf_cycle.sv */
// Single pin cycle engine: one read or one write on the flash pins.
// Assumes dq input is asynchronous; it is sampled through three flops.
`timescale 1ns/1ns
`default_nettype none
module pwf_cycle #(
   parameter int STROBE = pwf_pkg::STROBE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   pwf_cyc_if.eng cyc,
   output logic chip_sel_n,
   output logic out_gate_n,
   output logic wr_strobe_n,
   output logic [15:0] addr_pin,
   output logic [15:0] dq_out,
   output logic dq_oe_n,
   input wire logic [15:0] dq_in
);
   typedef enum logic [1:0] {PWF_C_IDLE, PWF_C_SETUP, PWF_C_PULSE,
      PWF_C_HOLD} pwf_cst_t;
   pwf_cst_t st; // Cycle state
   logic [7:0] cnt; // Strobe width counter
   logic [15:0] s1, s2, s3; // Data input synchroniser
   logic [15:0] dq_sync; // Settled data word

   // Three-stage data sampling
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= 16'h0000;
         s2 <= 16'h0000;
         s3 <= 16'h0000;
         dq_sync <= 16'h0000;
      end else if (ce) begin
         s1 <= dq_in;
         s2 <= s1;
         s3 <= s2;
         // A change counts only once the last two stages agree
         if (s2 == s3) begin
            dq_sync <= s3;
         end
      end
   end

   // Cycle sequence; address is set a cycle before the strobes fall,
   // so the device latches it on the first falling strobe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= PWF_C_IDLE;
         cnt <= 8'h00;
         chip_sel_n <= 1'b1;
         out_gate_n <= 1'b1;
         wr_strobe_n <= 1'b1;
         addr_pin <= 16'h0000;
         dq_out <= 16'h0000;
         dq_oe_n <= 1'b1;
         cyc.done <= 1'b0;
         cyc.rdata <= 16'h0000;
      end else if (ce) begin
         cyc.done <= 1'b0;
         unique case (st)
            PWF_C_IDLE: begin
               if (cyc.req) begin
                  addr_pin <= cyc.addr;
                  dq_out <= cyc.wdata;
                  // Output gate stays high through a write
                  dq_oe_n <= !cyc.wr;
                  out_gate_n <= 1'b1;
                  st <= PWF_C_SETUP;
               end
            end
            PWF_C_SETUP: begin
               chip_sel_n <= 1'b0;
               wr_strobe_n <= !cyc.wr;
               out_gate_n <= cyc.wr;
               cnt <= 8'h00;
               st <= PWF_C_PULSE;
            end
            PWF_C_PULSE: begin
               // Strobe stays well above the glitch limit; reads
               // wait three more cycles for the synchroniser
               cnt <= cnt + 8'h01;
               if (cnt == 8'(cyc.wr ? STROBE : STROBE + 3)) begin
                  cyc.rdata <= dq_sync;
                  chip_sel_n <= 1'b1;
                  wr_strobe_n <= 1'b1;
                  out_gate_n <= 1'b1;
                  st <= PWF_C_HOLD;
               end
            end
            PWF_C_HOLD: begin
               dq_oe_n <= 1'b1;
               cyc.done <= 1'b1;
               st <= PWF_C_IDLE;
            end
         endcase
      end
   end

   a_write_gate_high: assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_strobe_n |-> out_gate_n && !chip_sel_n)
      else $error("write strobe low while output gate low");
   a_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(wr_strobe_n) && ce |-> !wr_strobe_n [*2])
      else $error("write strobe pulse too short");
   a_read_drive_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !out_gate_n |-> dq_oe_n)
      else $error("host drives data while device reads out");
endmodule
`default_nettype wire

/* logic/pwf_host.sv */
// Host controller for a word-wide page-write flash.
// Assumes AXI4-Lite software access and an asynchronous device.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pwf_host #(
   parameter int LOAD_WIN = pwf_pkg::LOAD_WINDOW_CYC,
   parameter int PWRON = pwf_pkg::PWRON_CYC,
   parameter int ID_PAUSE = pwf_pkg::ID_PAUSE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic chip_sel_n,
   output logic out_gate_n,
   output logic wr_strobe_n,
   output logic [15:0] addr_pin,
   output logic [15:0] dq_out,
   output logic dq_oe_n,
   input wire logic [15:0] dq_in,
   output logic id_high_voltage_pin
);
   pwf_cyc_if cyc();
   // Sequencer states
   typedef enum logic [2:0] {PWF_S_IDLE, PWF_S_CMD, PWF_S_WAIT,
      PWF_S_READ, PWF_S_PAUSE} pwf_sst_t;
   pwf_sst_t st; // Sequencer state
   logic [3:0] ctrl_op; // Pending operation
   logic id_hv; // Hardware id request bit
   logic [15:0] op_addr; // Target word address
   logic [15:0] op_wdata; // Target write data
   logic [15:0] rdata; // Last read data
   logic busy, done, err; // Status
   logic [2:0] step; // Command word index
   logic [2:0] nsteps; // Prefix length
   logic [31:0] pwr_cnt; // Power-on delay count
   logic pwr_ok; // Delay elapsed
   logic [31:0] win_cnt; // Cycles since last load
   logic page_open; // A page load is under way
   logic [8:0] page_tag; // Page address of open page
   logic [31:0] pause_cnt; // Pause after every command op
   logic aw_hold, w_hold; // Captured write channels
   logic [4:0] aw_a;
   logic [31:0] w_d;
   logic start; // One-cycle op start

   // Command word table: address and data for step i of op
   function automatic logic [31:0] cmd_word(input logic [3:0] op,
      input logic [2:0] i);
      logic [15:0] a, d;
      a = (i == 3'd1 || i == 3'd4) ? pwf_pkg::CA_2AAA : pwf_pkg::CA_5555;
      d = (i == 3'd1 || i == 3'd4) ? pwf_pkg::CD_55 : pwf_pkg::CD_AA;
      if (op >= 4'(pwf_pkg::PWF_OP_ID3)) begin
         d = (i == 3'd1 || i == 3'd4) ? pwf_pkg::CD_ID_55 : pwf_pkg::CD_ID_AA;
      end
      if (i == 3'd2) begin
         unique case (op)
            4'(pwf_pkg::PWF_OP_LOAD): d = pwf_pkg::CD_A0;
            4'(pwf_pkg::PWF_OP_PROT_ON): d = pwf_pkg::CD_A0;
            4'(pwf_pkg::PWF_OP_ID3): d = pwf_pkg::CD_90;
            4'(pwf_pkg::PWF_OP_ID6): d = pwf_pkg::CD_ID_80;
            4'(pwf_pkg::PWF_OP_ID_EXIT): d = pwf_pkg::CD_F0;
            default: d = pwf_pkg::CD_80;
         endcase
      end
      if (i == 3'd5) begin
         unique case (op)
            4'(pwf_pkg::PWF_OP_PROT_OFF): d = pwf_pkg::CD_20;
            4'(pwf_pkg::PWF_OP_ERASE): d = pwf_pkg::CD_10;
            default: d = pwf_pkg::CD_60;
         endcase
      end
      return {a, d};
   endfunction

   // Prefix length per operation
   function automatic logic [2:0] prefix_len(input logic [3:0] op);
      unique case (op)
         4'(pwf_pkg::PWF_OP_PROT_OFF), 4'(pwf_pkg::PWF_OP_ERASE),
         4'(pwf_pkg::PWF_OP_ID6): return 3'd6;
         4'(pwf_pkg::PWF_OP_PROT_ON), 4'(pwf_pkg::PWF_OP_ID3),
         4'(pwf_pkg::PWF_OP_ID_EXIT): return 3'd3;
         // Loads prefix when no page is open, since protection may be on
         4'(pwf_pkg::PWF_OP_LOAD): return 3'd3;
         default: return 3'd0;
      endcase
   endfunction

   // Power-on delay before any write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_cnt <= 32'h0;
         pwr_ok <= 1'b0;
      end else if (clk_en && !pwr_ok) begin
         pwr_cnt <= pwr_cnt + 32'h1;
         pwr_ok <= (pwr_cnt >= 32'(PWRON));
      end
   end

   // Load window timer; lapse closes the page
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_cnt <= 32'h0;
      end else if (clk_en) begin
         if (cyc.done && cyc.wr) begin
            win_cnt <= 32'h0;
         end else if (page_open) begin
            win_cnt <= win_cnt + 32'h1;
         end
      end
   end

   // AXI write channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_a <= 5'h00;
         w_d <= 32'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pwf_pkg::RESP_OK;
         ctrl_op <= 4'(pwf_pkg::PWF_OP_NONE);
         id_hv <= 1'b0;
         op_addr <= 16'h0000;
         op_wdata <= 16'h0000;
         start <= 1'b0;
      end else if (clk_en) begin
         start <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_a <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_d <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (aw_hold && w_hold && !s_axi_bvalid) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= pwf_pkg::RESP_OK;
            unique case (aw_a)
               pwf_pkg::R_CTRL: begin
                  id_hv <= w_d[4];
                  if (!busy && w_d[3:0] != 4'(pwf_pkg::PWF_OP_NONE)) begin
                     ctrl_op <= w_d[3:0];
                     start <= 1'b1;
                  end
               end
               pwf_pkg::R_ADDR: op_addr <= w_d[15:0];
               pwf_pkg::R_WDATA: op_wdata <= w_d[15:0];
               pwf_pkg::R_STAT, pwf_pkg::R_RDATA: ;
               default: s_axi_bresp <= pwf_pkg::RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= pwf_pkg::RESP_OK;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pwf_pkg::RESP_OK;
            unique case (s_axi_araddr)
               pwf_pkg::R_CTRL: s_axi_rdata <= {27'h0, id_hv, ctrl_op};
               pwf_pkg::R_ADDR: s_axi_rdata <= {16'h0, op_addr};
               pwf_pkg::R_WDATA: s_axi_rdata <= {16'h0, op_wdata};
               pwf_pkg::R_STAT: s_axi_rdata <= {28'h0, err, pwr_ok, done,
                  busy};
               pwf_pkg::R_RDATA: s_axi_rdata <= {16'h0, rdata};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= pwf_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Operation sequencer: command prefix, data word, read, pauses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= PWF_S_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         step <= 3'd0;
         nsteps <= 3'd0;
         page_open <= 1'b0;
         page_tag <= 9'h000;
         pause_cnt <= 32'h0;
         rdata <= 16'h0000;
         cyc.req <= 1'b0;
         cyc.wr <= 1'b0;
         cyc.addr <= 16'h0000;
         cyc.wdata <= 16'h0000;
         id_high_voltage_pin <= 1'b0;
      end else if (clk_en) begin
         cyc.req <= 1'b0;
         id_high_voltage_pin <= id_hv;
         if (page_open && win_cnt >= 32'(LOAD_WIN)) begin
            page_open <= 1'b0;
         end
         unique case (st)
            PWF_S_IDLE: begin
               if (start) begin
                  done <= 1'b0;
                  err <= 1'b0;
                  busy <= 1'b1;
                  step <= 3'd0;
                  nsteps <= prefix_len(ctrl_op);
                  if (ctrl_op == 4'(pwf_pkg::PWF_OP_READ)) begin
                     cyc.req <= 1'b1;
                     cyc.wr <= 1'b0;
                     cyc.addr <= op_addr;
                     st <= PWF_S_READ;
                  end else if (!pwr_ok || prefix_len(ctrl_op) == 3'd0 ||
                     (page_open && (ctrl_op != 4'(pwf_pkg::PWF_OP_LOAD) ||
                     op_addr[15:pwf_pkg::WORD_BITS] != page_tag))) begin
                     // Refuse unknown ops; no page mixing, and no
                     // command words into an open page either
                     err <= 1'b1;
                     busy <= 1'b0;
                  end else begin
                     st <= PWF_S_CMD;
                  end
               end
            end
            PWF_S_CMD: begin
               cyc.req <= 1'b1;
               cyc.wr <= 1'b1;
               if (step < nsteps && !(page_open &&
                  ctrl_op == 4'(pwf_pkg::PWF_OP_LOAD))) begin
                  {cyc.addr, cyc.wdata} <= cmd_word(ctrl_op, step);
               end else begin
                  // Data word: low bits pick the slot
                  cyc.addr <= op_addr;
                  cyc.wdata <= op_wdata;
                  step <= 3'd7;
               end
               st <= PWF_S_WAIT;
            end
            PWF_S_WAIT: begin
               if (cyc.done) begin
                  if (step == 3'd7) begin
                     page_open <= 1'b1;
                     page_tag <= op_addr[15:pwf_pkg::WORD_BITS];
                     busy <= 1'b0;
                     done <= 1'b1;
                     st <= PWF_S_IDLE;
                  end else if (step + 3'd1 == nsteps &&
                     ctrl_op != 4'(pwf_pkg::PWF_OP_LOAD)) begin
                     pause_cnt <= 32'h0;
                     st <= PWF_S_PAUSE;
                  end else begin
                     step <= step + 3'd1;
                     st <= PWF_S_CMD;
                  end
               end
            end
            PWF_S_READ: begin
               if (cyc.done) begin
                  rdata <= cyc.rdata;
                  busy <= 1'b0;
                  done <= 1'b1;
                  st <= PWF_S_IDLE;
               end
            end
            PWF_S_PAUSE: begin
               // Pause after every command op, id and others; erase and protect
               // completion are polled by software reads
               pause_cnt <= pause_cnt + 32'h1;
               if (pause_cnt >= 32'(ID_PAUSE)) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  st <= PWF_S_IDLE;
               end
            end
            default: st <= PWF_S_IDLE;
         endcase
      end
   end

   // Pin cycle engine
   pwf_cycle pwf_cycle_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(clk_en),
      .cyc(cyc),
      .chip_sel_n(chip_sel_n),
      .out_gate_n(out_gate_n),
      .wr_strobe_n(wr_strobe_n),
      .addr_pin(addr_pin),
      .dq_out(dq_out),
      .dq_oe_n(dq_oe_n),
      .dq_in(dq_in)
   );

   a_no_write_early: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwr_ok |-> wr_strobe_n)
      else $error("write issued before power-on delay");
   a_page_lapse: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && page_open && !cyc.done && win_cnt >= 32'(LOAD_WIN)
      |=> !page_open)
      else $error("page stayed open past load window");
   a_page_same: assert property (@(posedge aclk) disable iff (!aresetn)
      page_open && $past(page_open) && clk_en |-> $stable(page_tag))
      else $error("page address changed inside page");
   a_cmd_first: assert property (@(posedge aclk) disable iff (!aresetn)
      st == PWF_S_CMD && step == 3'd0 && nsteps != 3'd0 && !page_open
      |=> cyc.addr == pwf_pkg::CA_5555)
      else $error("command prefix not at first command address");
   a_busy_done: assert property (@(posedge aclk) disable iff (!aresetn)
      done |-> !busy)
      else $error("done and busy together");
endmodule
`default_nettype wire
